// ===== hdl/lsg_pkg.sv
// Package: register map, field layout, reset values and pin mode codes of the link status block
package lsg_pkg;

	localparam int          LSG_DATA_W           = 32;
	localparam int          LSG_ADDR_W           = 8;
	localparam int          LSG_IDX_W            = LSG_ADDR_W - 2;
	localparam int          LSG_PORTS            = 2;

	// Register indices; byte address is four times the index
	localparam logic [5:0]  LSG_IDX_CTRL         = 6'h04;
	localparam logic [5:0]  LSG_IDX_CRC_LO       = 6'h0A;
	localparam logic [5:0]  LSG_IDX_CRC_HI       = 6'h0B;
	localparam logic [5:0]  LSG_IDX_STATUS       = 6'h0C;
	localparam logic [5:0]  LSG_IDX_PIN0         = 6'h0D;

	// Control register fields
	localparam int          LSG_CTRL_PSEL_BIT    = 0;
	localparam int          LSG_CTRL_CRC_RST_BIT = 5;
	localparam logic [7:0]  LSG_CTRL_RST         = 8'h00;

	// Status register fields
	localparam int          LSG_ST_LOST_BIT      = 4;
	localparam int          LSG_ST_BIST_BIT      = 3;
	localparam int          LSG_ST_PCLK_BIT      = 2;
	localparam int          LSG_ST_DES_BIT       = 1;
	localparam int          LSG_ST_DET_BIT       = 0;

	// Pin configuration fields
	localparam int          LSG_PIN_REV_LSB      = 4;
	localparam int          LSG_PIN_VAL_BIT      = 3;
	localparam int          LSG_PIN_MODE_LSB     = 0;
	localparam logic        LSG_PIN_VAL_RST      = 1'b0;
	localparam logic [2:0]  LSG_PIN_MODE_RST     = 3'h0;

	// Pin mode codes; the top bit is ignored for the first two
	localparam logic [1:0]  LSG_MODE_FUNC_IN     = 2'h0;
	localparam logic [1:0]  LSG_MODE_HIZ         = 2'h2;
	localparam logic [2:0]  LSG_MODE_GP_OUT      = 3'h1;
	localparam logic [2:0]  LSG_MODE_GP_IN       = 3'h3;
	localparam logic [2:0]  LSG_MODE_RMT_HOLD    = 3'h5;
	localparam logic [2:0]  LSG_MODE_RMT_DFLT    = 3'h7;

	localparam logic [15:0] LSG_CNT_RST          = 16'h0000;
	localparam logic [15:0] LSG_CNT_MAX          = 16'hFFFF;

	typedef struct packed {
		logic [15:0] cnt;
		logic        link_lost;
		logic        bist_flag;
		logic        des_flag;
		logic        det_prev;
	} lsg_stat_t;

endpackage : lsg_pkg

// ===== hdl/lsg_port_if.sv
// Interface: per-port events in, per-port flags and counter out
`timescale 1ns/10ps
`default_nettype none
interface lsg_port_if;
	logic        clr;
	logic        link_det;
	logic        bc_crc_err;
	logic        bist_crc_err;
	logic        bist_restart;
	logic        des_crc_err;
	logic [15:0] cnt;
	logic        link_lost;
	logic        bist_flag;
	logic        des_flag;

	modport stat (
		input  clr, link_det, bc_crc_err, bist_crc_err, bist_restart, des_crc_err,
		output cnt, link_lost, bist_flag, des_flag
	);
	modport ctl (
		output clr, link_det, bc_crc_err, bist_crc_err, bist_restart, des_crc_err,
		input  cnt, link_lost, bist_flag, des_flag
	);
endinterface : lsg_port_if
`default_nettype wire

// ===== hdl/lsg_port_stat.sv
// Per-port error counter and sticky status flags
`timescale 1ns/10ps
`default_nettype none
module lsg_port_stat
	import lsg_pkg::*;
(
	input  wire logic clk,
	input  wire logic rst,
	lsg_port_if.stat  pif
);
	lsg_stat_t   s_q;
	lsg_stat_t   s_d;
	logic        lost;
	logic [15:0] base;

	// Loss of link is the falling edge of cable detect
	assign lost = s_q.det_prev & ~pif.link_det;

	always_comb
	begin
		s_d          = s_q;
		s_d.det_prev = pif.link_det;
		base         = pif.clr ? LSG_CNT_RST : s_q.cnt;
		// An error in the clearing cycle still counts; stop at full scale
		if (pif.bc_crc_err && (base != LSG_CNT_MAX))
			s_d.cnt = base + 16'h0001;
		else
			s_d.cnt = base;
		s_d.link_lost = lost | (s_q.link_lost & ~pif.clr);
		s_d.bist_flag = pif.bist_crc_err
			| (s_q.bist_flag & ~(pif.clr | lost | pif.bist_restart));
		s_d.des_flag  = pif.des_crc_err | (s_q.des_flag & ~(pif.clr | lost));
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			s_q <= '{cnt: LSG_CNT_RST, default: 1'b0};
		else
			s_q <= s_d;
	end

	assign pif.cnt       = s_q.cnt;
	assign pif.link_lost = s_q.link_lost;
	assign pif.bist_flag = s_q.bist_flag;
	assign pif.des_flag  = s_q.des_flag;

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	property p_cnt_sat;
		(pif.cnt == LSG_CNT_MAX) && !pif.clr |=> (pif.cnt == LSG_CNT_MAX);
	endproperty
	a_cnt_sat: assert property (p_cnt_sat) else $error("count left full scale");

	property p_cnt_clr;
		pif.clr && !pif.bc_crc_err |=> (pif.cnt == LSG_CNT_RST);
	endproperty
	a_cnt_clr: assert property (p_cnt_clr) else $error("count not cleared");

	property p_cnt_inc;
		!pif.clr && pif.bc_crc_err && (pif.cnt != LSG_CNT_MAX)
			|=> (pif.cnt == $past(pif.cnt) + 16'h0001);
	endproperty
	a_cnt_inc: assert property (p_cnt_inc) else $error("count missed an error");

	property p_lost_set;
		$fell(pif.link_det) |=> pif.link_lost;
	endproperty
	a_lost_set: assert property (p_lost_set) else $error("link lost not set");

	property p_lost_hold;
		pif.link_lost && !pif.clr |=> pif.link_lost;
	endproperty
	a_lost_hold: assert property (p_lost_hold) else $error("link lost dropped");

	property p_bist_clr;
		pif.bist_restart && !pif.bist_crc_err |=> !pif.bist_flag;
	endproperty
	a_bist_clr: assert property (p_bist_clr) else $error("self-test flag kept");

	property p_des_clr;
		$fell(pif.link_det) ##0 !pif.des_crc_err |=> !pif.des_flag;
	endproperty
	a_des_clr: assert property (p_des_clr) else $error("error flag kept on loss");

	c_sat:  cover property (pif.bc_crc_err && (pif.cnt == LSG_CNT_MAX));
	c_lost: cover property ($fell(pif.link_det) ##1 pif.link_lost ##[1:20] pif.clr);
endmodule : lsg_port_stat
`default_nettype wire

// ===== hdl/lsg_regs.sv
// Link status and pin zero register bank with APB slave
`timescale 1ns/10ps
`default_nettype none
module lsg_regs
	import lsg_pkg::*;
#(
	parameter logic [3:0] REV_ID = 4'h1 // Arbitrary value
)
(
	input  wire logic                  core_clk,
	input  wire logic                  rst,
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [LSG_ADDR_W-1:0] paddr,
	input  wire logic [LSG_DATA_W-1:0] pwdata,
	input  wire logic [3:0]            pstrb,
	output logic      [LSG_DATA_W-1:0] prdata,
	output logic                       pready,
	output logic                       pslverr,
	input  wire logic [1:0]            link_detect,
	input  wire logic [1:0]            bc_crc_err,
	input  wire logic [1:0]            bist_crc_err,
	input  wire logic [1:0]            bist_restart,
	input  wire logic [1:0]            des_crc_err,
	input  wire logic                  input_pixel_clock_present,
	input  wire logic [1:0]            remote_pin_val,
	input  wire logic [1:0]            pin_zero_in,
	output logic      [1:0]            pin_zero_out,
	output logic      [1:0]            pin_zero_oe_n,
	output logic      [1:0]            pin_zero_func_in
);
	typedef struct packed {
		logic [7:0]            ctrl;
		logic [1:0]            pin_val;
		logic [1:0][2:0]       pin_mode;
		logic [1:0]            rmt_hold;
		logic [1:0]            pin_out;
		logic [1:0]            pin_oe_n;
		logic [1:0]            func_in;
		logic [1:0]            det;
		logic                  pclk;
		logic [LSG_DATA_W-1:0] prdata;
		logic                  pready;
		logic                  pslverr;
	} lsg_regs_t;

	lsg_regs_t            s_q;
	lsg_regs_t            s_d;
	lsg_port_if           pif [LSG_PORTS] ();
	logic                 port_sel;
	logic [LSG_IDX_W-1:0] idx;
	logic                 hit;
	logic                 access;
	logic [15:0]          cnt_sel;
	logic [7:0]           status_sel;
	logic [15:0]          cnt_p [LSG_PORTS];
	logic [LSG_PORTS-1:0] lost_p;
	logic [LSG_PORTS-1:0] bist_p;
	logic [LSG_PORTS-1:0] des_p;

	assign port_sel = s_q.ctrl[LSG_CTRL_PSEL_BIT];
	assign idx      = paddr[LSG_ADDR_W-1:2];
	assign access   = psel & penable;
	assign hit      = (idx == LSG_IDX_CTRL) || (idx == LSG_IDX_CRC_LO) || (idx == LSG_IDX_CRC_HI)
		|| (idx == LSG_IDX_STATUS) || (idx == LSG_IDX_PIN0);

	genvar g;
	generate
		for (g = 0; g < LSG_PORTS; g++)
		begin : g_port
			assign pif[g].clr          = s_q.ctrl[LSG_CTRL_CRC_RST_BIT];
			assign pif[g].link_det     = link_detect[g];
			assign pif[g].bc_crc_err   = bc_crc_err[g];
			assign pif[g].bist_crc_err = bist_crc_err[g];
			assign pif[g].bist_restart = bist_restart[g];
			assign pif[g].des_crc_err  = des_crc_err[g];
			assign cnt_p[g]            = pif[g].cnt;
			assign lost_p[g]           = pif[g].link_lost;
			assign bist_p[g]           = pif[g].bist_flag;
			assign des_p[g]            = pif[g].des_flag;
			lsg_port_stat u_stat (
				.clk (core_clk),
				.rst (rst),
				.pif (pif[g])
			);
		end
	endgenerate

	// Per-port views follow the port select
	always_comb
	begin
		cnt_sel    = port_sel ? cnt_p[1] : cnt_p[0];
		status_sel = 8'h00;
		status_sel[LSG_ST_LOST_BIT] = port_sel ? lost_p[1] : lost_p[0];
		status_sel[LSG_ST_BIST_BIT] = port_sel ? bist_p[1] : bist_p[0];
		status_sel[LSG_ST_PCLK_BIT] = s_q.pclk;
		status_sel[LSG_ST_DES_BIT]  = port_sel ? des_p[1] : des_p[0];
		status_sel[LSG_ST_DET_BIT]  = port_sel ? s_q.det[1] : s_q.det[0];
	end

	always_comb
	begin
		s_d         = s_q;
		s_d.pready  = 1'b0;
		s_d.pslverr = 1'b0;
		s_d.det     = link_detect;
		s_d.pclk    = input_pixel_clock_present;

		// One wait state: answer is prepared in the first access cycle
		if (access && !s_q.pready)
		begin
			s_d.pready  = 1'b1;
			s_d.pslverr = !hit;
			s_d.prdata  = '0;
			unique case (1'b1)
				(idx == LSG_IDX_CTRL):   s_d.prdata[7:0] = s_q.ctrl;
				(idx == LSG_IDX_CRC_LO): s_d.prdata[7:0] = cnt_sel[7:0];
				(idx == LSG_IDX_CRC_HI): s_d.prdata[7:0] = cnt_sel[15:8];
				(idx == LSG_IDX_STATUS): s_d.prdata[7:0] = status_sel;
				(idx == LSG_IDX_PIN0):
				begin
					s_d.prdata[LSG_PIN_REV_LSB +: 4]  = REV_ID;
					s_d.prdata[LSG_PIN_VAL_BIT]       = s_q.pin_val[port_sel];
					s_d.prdata[LSG_PIN_MODE_LSB +: 3] = s_q.pin_mode[port_sel];
				end
				default: s_d.prdata = '0;
			endcase
		end

		// Only control and pin fields are writable; all else ignores writes
		if (access && s_q.pready && pwrite && pstrb[0])
		begin
			if (idx == LSG_IDX_CTRL)
				s_d.ctrl = pwdata[7:0];
			if (idx == LSG_IDX_PIN0)
			begin
				s_d.pin_val[port_sel]  = pwdata[LSG_PIN_VAL_BIT];
				s_d.pin_mode[port_sel] = pwdata[LSG_PIN_MODE_LSB +: 3];
			end
		end

		for (int i = 0; i < LSG_PORTS; i++)
		begin
			// Remote value is only trusted while the link is up
			if (link_detect[i])
				s_d.rmt_hold[i] = remote_pin_val[i];
			s_d.func_in[i]  = 1'b0;
			s_d.pin_oe_n[i] = 1'b1;
			s_d.pin_out[i]  = 1'b0;
			casez (s_q.pin_mode[i])
				3'b?00:
					s_d.func_in[i] = pin_zero_in[i];
				3'b?10:
					s_d.pin_oe_n[i] = 1'b1;
				LSG_MODE_GP_OUT:
				begin
					s_d.pin_oe_n[i] = 1'b0;
					s_d.pin_out[i]  = s_q.pin_val[i];
				end
				LSG_MODE_GP_IN:
					s_d.pin_oe_n[i] = 1'b1;
				LSG_MODE_RMT_HOLD:
				begin
					s_d.pin_oe_n[i] = 1'b0;
					s_d.pin_out[i]  = link_detect[i] ? remote_pin_val[i]
						: s_q.rmt_hold[i];
				end
				default:
				begin
					s_d.pin_oe_n[i] = 1'b0;
					s_d.pin_out[i]  = link_detect[i] ? remote_pin_val[i]
						: s_q.pin_val[i];
				end
			endcase
		end
	end

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			s_q          <= '0;
			s_q.ctrl     <= LSG_CTRL_RST;
			s_q.pin_val  <= {LSG_PORTS{LSG_PIN_VAL_RST}};
			s_q.pin_mode <= {LSG_PORTS{LSG_PIN_MODE_RST}};
			s_q.pin_oe_n <= 2'h3;
		end
		else
			s_q <= s_d;
	end

	assign prdata           = s_q.prdata;
	assign pready           = s_q.pready;
	assign pslverr          = s_q.pslverr;
	assign pin_zero_out     = s_q.pin_out;
	assign pin_zero_oe_n    = s_q.pin_oe_n;
	assign pin_zero_func_in = s_q.func_in;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	property p_pready_pulse;
		pready |=> !pready;
	endproperty
	a_pready_pulse: assert property (p_pready_pulse) else $error("ready held too long");

	property p_unmapped;
		access && !pready && !hit |=> pready && pslverr;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped access not flagged");

	property p_gp_out;
		(s_q.pin_mode[0] == LSG_MODE_GP_OUT)
			|=> !pin_zero_oe_n[0] && (pin_zero_out[0] == $past(s_q.pin_val[0]));
	endproperty
	a_gp_out: assert property (p_gp_out) else $error("output mode not driving value");

	property p_hiz;
		(s_q.pin_mode[1][1:0] == LSG_MODE_HIZ) |=> pin_zero_oe_n[1];
	endproperty
	a_hiz: assert property (p_hiz) else $error("high impedance mode drives");

	property p_rmt_hold;
		(s_q.pin_mode[0] == LSG_MODE_RMT_HOLD) && !link_detect[0] [*2]
			|=> $stable(pin_zero_out[0]) && !pin_zero_oe_n[0];
	endproperty
	a_rmt_hold: assert property (p_rmt_hold) else $error("held value changed on loss");

	property p_rmt_dflt;
		(s_q.pin_mode[0] == LSG_MODE_RMT_DFLT) && !link_detect[0]
			|=> (pin_zero_out[0] == $past(s_q.pin_val[0]));
	endproperty
	a_rmt_dflt: assert property (p_rmt_dflt) else $error("local value not substituted");

	property p_sel_write;
		access && pready && pwrite && pstrb[0] && (idx == LSG_IDX_PIN0) && port_sel
			|=> (s_q.pin_val[1] == $past(pwdata[LSG_PIN_VAL_BIT]))
			&& (s_q.pin_mode[1] == $past(pwdata[2:0]));
	endproperty
	a_sel_write: assert property (p_sel_write) else $error("write missed second port");

	property p_cnt_read;
		access && !pready && !pwrite && (idx == LSG_IDX_CRC_HI)
			|=> (prdata[7:0] == $past(cnt_sel[15:8])) && (prdata[31:8] == 24'h000000);
	endproperty
	a_cnt_read: assert property (p_cnt_read) else $error("count high byte misread");

	property p_det;
		link_detect[0] ##1 !port_sel |-> status_sel[LSG_ST_DET_BIT];
	endproperty
	a_det: assert property (p_det) else $error("link detect not reported");

	// The edge that releases reset still loads reset values, so start one edge later
	property p_pclk;
		!rst ##1 input_pixel_clock_present |=> status_sel[LSG_ST_PCLK_BIT];
	endproperty
	a_pclk: assert property (p_pclk) else $error("pixel clock not reported");

	property p_sel_cnt_read;
		access && !pready && !pwrite && (idx == LSG_IDX_CRC_LO) && port_sel
			|=> (prdata[7:0] == $past(cnt_p[1][7:0]));
	endproperty
	a_sel_cnt_read: assert property (p_sel_cnt_read) else $error("second port count misread");

	property p_rmt_dflt_up;
		(s_q.pin_mode[0] == LSG_MODE_RMT_DFLT) && link_detect[0]
			|=> !pin_zero_oe_n[0] && (pin_zero_out[0] == $past(remote_pin_val[0]));
	endproperty
	a_rmt_dflt_up: assert property (p_rmt_dflt_up) else $error("remote value not driven");

	property p_ro_write;
		access && pready && pwrite && (idx != LSG_IDX_CTRL) |=> (s_q.ctrl == $past(s_q.ctrl));
	endproperty
	a_ro_write: assert property (p_ro_write) else $error("control changed by other write");

	property p_rsvd_read;
		access && !pready && !pwrite && (idx == LSG_IDX_STATUS)
			|=> (prdata[7:5] == 3'h0) && (prdata[31:8] == 24'h000000);
	endproperty
	a_rsvd_read: assert property (p_rsvd_read) else $error("reserved status bits set");

	property p_func_in;
		(s_q.pin_mode[0][1:0] != LSG_MODE_FUNC_IN) |=> !pin_zero_func_in[0];
	endproperty
	a_func_in: assert property (p_func_in) else $error("functional input leaked");

	property p_gp_out2;
		(s_q.pin_mode[1] == LSG_MODE_GP_OUT)
			|=> !pin_zero_oe_n[1] && (pin_zero_out[1] == $past(s_q.pin_val[1]));
	endproperty
	a_gp_out2: assert property (p_gp_out2) else $error("second port pin not driven");

	c_write:    cover property (access && pready && pwrite && (idx == LSG_IDX_PIN0));
	c_rmt_loss: cover property ((s_q.pin_mode[0] == LSG_MODE_RMT_HOLD) ##1 $fell(link_detect[0]));
	c_port2:    cover property (port_sel && access && pready && (idx == LSG_IDX_STATUS));
endmodule : lsg_regs
`default_nettype wire

// ===== sim/lsg_remote_model.sv
// Far-side model: remote receiver link, error events and pin peer
`timescale 1ns/10ps
`default_nettype none
module lsg_remote_model (
	input  wire logic       core_clk,
	input  wire logic [1:0] pin_zero_out,
	input  wire logic [1:0] pin_zero_oe_n,
	output wire logic [1:0] pin_zero_in,
	output logic      [1:0] link_detect,
	output logic      [1:0] bc_crc_err,
	output logic      [1:0] bist_crc_err,
	output logic      [1:0] bist_restart,
	output logic      [1:0] des_crc_err,
	output logic      [1:0] remote_pin_val
);
	// Keeper level on a pin that nobody drives
	localparam logic [1:0] EXT = 2'h1;
	logic [1:0] rmt;
	assign pin_zero_in = (~pin_zero_oe_n & pin_zero_out) | (pin_zero_oe_n & EXT);
	initial
	begin
		{link_detect, bc_crc_err, bist_crc_err, bist_restart, des_crc_err} = 10'h0;
		remote_pin_val = 2'h0;
		rmt = 2'h0;
	end
	// A lost link carries no value, so the last one must not linger
	always @(posedge core_clk)
		remote_pin_val <= (link_detect & rmt) | (~link_detect & ~remote_pin_val);
	task automatic link(input int p, input logic v);
		@(posedge core_clk);
		link_detect[p] <= v;
	endtask : link
	task automatic rv(input int p, input logic v);
		rmt[p] <= v;
	endtask : rv
	// Error kinds in k: back channel, self-test, restart, normal traffic
	task automatic ev(input logic [3:0] k, input int p, input int n);
		@(posedge core_clk);
		{bc_crc_err[p], bist_crc_err[p], bist_restart[p], des_crc_err[p]} <= {k[0], k[1], k[2], k[3]};
		repeat (n) @(posedge core_clk);
		{bc_crc_err[p], bist_crc_err[p], bist_restart[p], des_crc_err[p]} <= 4'h0;
	endtask : ev
endmodule : lsg_remote_model
`default_nettype wire

// ===== sim/lsg_regs_tb_top.sv
// Testbench: APB register checks against the remote link model
`timescale 1ns/10ps
`default_nettype none
module lsg_regs_tb_top;
	import lsg_pkg::*;
	localparam logic [3:0] REV = 4'h1; // Arbitrary value
	typedef struct packed {
		logic       w;
		logic [5:0] i;
		logic [7:0] d;
		logic [7:0] x;
		logic       e;
	} lsg_row_t;
	logic        core_clk, rst, psel, penable, pwrite, pix, pready, pslverr, rerr;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rdat;
	logic [3:0]  pstrb;
	logic [1:0]  ld, bce, bie, brs, dce, rpv, pin, pout, poe, pfi;
	int          error_cnt, compares;
	lsg_row_t    rows [10];
	logic [2:0]  md [5] = '{3'h0, 3'h2, 3'h3, 3'h4, 3'h6};
	logic [1:0]  fx [5] = '{2'h3, 2'h2, 2'h2, 2'h3, 2'h2};
	always #5 core_clk = ~core_clk;
	lsg_regs #(.REV_ID(REV)) lsg_regs_inst (.core_clk(core_clk), .rst(rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .link_detect(ld),
		.bc_crc_err(bce), .bist_crc_err(bie), .bist_restart(brs), .des_crc_err(dce),
		.input_pixel_clock_present(pix), .remote_pin_val(rpv), .pin_zero_in(pin),
		.pin_zero_out(pout), .pin_zero_oe_n(poe), .pin_zero_func_in(pfi));
	lsg_remote_model lsg_remote_model_inst (.core_clk(core_clk), .pin_zero_out(pout),
		.pin_zero_oe_n(poe), .pin_zero_in(pin), .link_detect(ld), .bc_crc_err(bce),
		.bist_crc_err(bie), .bist_restart(brs), .des_crc_err(dce), .remote_pin_val(rpv));
	task automatic summarize;
		$display("errors %0d compares %0d", error_cnt, compares);
		if (error_cnt == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : summarize
	task automatic chk(input logic [31:0] s, input logic [31:0] x);
		compares++;
		if (s !== x)
		begin
			error_cnt++;
			$display("ERROR %0t: got %h expected %h", $time, s, x);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [5:0] i, input logic [7:0] d);
		int n;
		@(posedge core_clk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= {i, 2'h0};
		pwdata <= {24'h0, d};
		@(posedge core_clk);
		penable <= 1'h1;
		n = 0;
		// Request stands until pready is seen high at a rising edge
		do
		begin
			@(posedge core_clk);
			n++;
		end
		while (pready !== 1'h1 && n < 20);
		if (pready !== 1'h1)
		begin
			error_cnt++;
			summarize();
		end
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask : apb
	task automatic rd(input logic [5:0] i, input logic [7:0] x);
		apb(1'h0, i, 8'h00);
		chk(rdat, {24'h0, x});
	endtask : rd
	task automatic pk(input int p, input logic [1:0] x);
		repeat (3) @(negedge core_clk);
		chk({30'h0, pout[p], poe[p]}, {30'h0, x});
	endtask : pk
	initial
	begin
		{core_clk, psel, penable, pwrite, pix} = 5'h0;
		rst = 1'h1;
		paddr = 8'h00;
		pwdata = 32'h0;
		pstrb = 4'hF;
		error_cnt = 0;
		compares = 0;
		rows = '{'{1'h0, 6'h0B, 8'h00, 8'h00, 1'h0},
			'{1'h0, 6'h0A, 8'h00, 8'h00, 1'h0},
			'{1'h0, 6'h0C, 8'h00, 8'h00, 1'h0},
			'{1'h0, 6'h0D, 8'h00, {REV, 4'h0}, 1'h0},
			'{1'h1, 6'h0D, 8'hFB, 8'h00, 1'h0},
			'{1'h0, 6'h0D, 8'h00, {REV, 4'hB}, 1'h0},
			'{1'h1, 6'h0B, 8'hFF, 8'h00, 1'h0},
			'{1'h0, 6'h0B, 8'h00, 8'h00, 1'h0},
			'{1'h0, 6'h3F, 8'h00, 8'h00, 1'h1},
			'{1'h1, 6'h3E, 8'hFF, 8'h00, 1'h1}};
		repeat (12) @(posedge core_clk);
		rst <= 1'h0;
		foreach (rows[k])
		begin
			apb(rows[k].w, rows[k].i, rows[k].d);
			chk(rerr, rows[k].e);
			if (!rows[k].w)
				chk(rdat, {24'h0, rows[k].x});
		end
		lsg_remote_model_inst.link(0, 1'h1);
		lsg_remote_model_inst.ev(4'h1, 0, 3);
		rd(6'h0A, 8'h03);
		rd(6'h0B, 8'h00);
		lsg_remote_model_inst.ev(4'h8, 0, 1);
		lsg_remote_model_inst.ev(4'h2, 0, 1);
		rd(6'h0C, 8'h0B);
		lsg_remote_model_inst.ev(4'h4, 0, 1);
		rd(6'h0C, 8'h03);
		pix <= 1'h1;
		rd(6'h0C, 8'h07);
		apb(1'h1, 6'h04, 8'h01);
		rd(6'h0A, 8'h00);
		rd(6'h0C, 8'h04);
		apb(1'h1, 6'h04, 8'h00);
		lsg_remote_model_inst.ev(4'hA, 0, 1);
		lsg_remote_model_inst.link(0, 1'h0);
		rd(6'h0C, 8'h14);
		rd(6'h0A, 8'h03);
		apb(1'h1, 6'h04, 8'h20);
		apb(1'h1, 6'h04, 8'h00);
		rd(6'h0C, 8'h04);
		rd(6'h0A, 8'h00);
		lsg_remote_model_inst.link(0, 1'h1);
		lsg_remote_model_inst.ev(4'h1, 0, 65540);
		rd(6'h0B, 8'hFF);
		rd(6'h0A, 8'hFF);
		apb(1'h1, 6'h04, 8'h20);
		apb(1'h1, 6'h04, 8'h00);
		rd(6'h0B, 8'h00);
		for (int k = 0; k < 5; k++)
		begin
			apb(1'h1, 6'h0D, {5'h0, md[k]});
			repeat (3) @(negedge core_clk);
			chk({30'h0, poe[0], pfi[0]}, {30'h0, fx[k]});
		end
		apb(1'h1, 6'h0D, 8'h09);
		pk(0, 2'h2);
		apb(1'h1, 6'h0D, 8'h01);
		pk(0, 2'h0);
		lsg_remote_model_inst.rv(0, 1'h1);
		apb(1'h1, 6'h0D, 8'h05);
		pk(0, 2'h2);
		lsg_remote_model_inst.link(0, 1'h0);
		pk(0, 2'h2);
		pk(0, 2'h2);
		lsg_remote_model_inst.link(0, 1'h1);
		apb(1'h1, 6'h0D, 8'h07);
		pk(0, 2'h2);
		lsg_remote_model_inst.link(0, 1'h0);
		pk(0, 2'h0);
		apb(1'h1, 6'h04, 8'h01);
		apb(1'h1, 6'h0D, 8'h09);
		pk(1, 2'h2);
		pk(0, 2'h0);
		apb(1'h1, 6'h0D, 8'h02);
		pk(1, 2'h1);
		@(posedge core_clk);
		rst <= 1'h1;
		repeat (2) @(posedge core_clk);
		chk({28'h0, poe, pout}, 32'h0000000C);
		rst <= 1'h0;
		rd(6'h0D, {REV, 4'h0});
		rd(6'h0C, 8'h04);
		summarize();
	end
endmodule : lsg_regs_tb_top
`default_nettype wire
